// *** hdl/gssm_pkg.sv ***
`default_nettype none
package gssm_pkg;
	localparam int unsigned CLK_HZ         = 125_000_000;
	localparam int unsigned HOLD_SEL_S     = 3;
	localparam int unsigned HOLD_DEF_S     = 5;
	localparam int unsigned DEBOUNCE_US    = 10_000;
	localparam int unsigned TICK_US        = 1_000;
	// Timebase tick of 1 ms; hold times counted in ticks
	localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned SEL_HOLD_TICKS = HOLD_SEL_S * 1_000_000 / TICK_US;
	localparam int unsigned DEF_HOLD_TICKS = HOLD_DEF_S * 1_000_000 / TICK_US;
	localparam int unsigned DEB_TICKS      = DEBOUNCE_US / TICK_US;
	localparam int unsigned VAL_W          = 16;
	// Values in mTorr
	localparam logic [15:0] DEF_ON_MTORR   = 16'h0064;
	localparam logic [15:0] DEF_OFF_MTORR  = 16'h00c8;
	localparam logic [15:0] DEF_ZERO_MTORR = 16'h0000;
	// Span in Torr
	localparam logic [15:0] DEF_SPAN_TORR  = 16'h02f8;
	localparam logic [15:0] CODE_ZERO      = 16'h0000;
	// Display text selector codes
	localparam logic [1:0] SHOW_PRESS      = 2'h0;
	localparam logic [1:0] SHOW_VALUE      = 2'h1;
	localparam logic [1:0] SHOW_DEF_TEXT   = 2'h2;
	// AXI-Lite map
	localparam logic [5:0] A_ON            = 6'h00;
	localparam logic [5:0] A_OFF           = 6'h04;
	localparam logic [5:0] A_ZERO          = 6'h08;
	localparam logic [5:0] A_SPAN          = 6'h0c;
	localparam logic [5:0] A_STATUS        = 6'h10;
	localparam logic [5:0] A_PRESS         = 6'h14;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;
	typedef enum logic [6:0] {
		GSSM_NORMAL = 7'h01,
		GSSM_SP_ON  = 7'h02,
		GSSM_SP_OFF = 7'h04,
		GSSM_ZERO   = 7'h08,
		GSSM_SPAN   = 7'h10,
		GSSM_DEF    = 7'h20,
		GSSM_WAIT   = 7'h40
	} gssm_state_t;
endpackage
`default_nettype wire

// *** hdl/gssm_key.sv ***
`timescale 1ns/100ps
`default_nettype none
module gssm_key #(
	parameter int unsigned DEB = gssm_pkg::DEB_TICKS,
	parameter int unsigned CW  = 14
) (
	input  wire logic          i_clock,
	input  wire logic          i_rst,
	input  wire logic          i_tick,
	input  wire logic          i_pin,
	output logic               o_down,
	output logic               o_press,
	output logic               o_release,
	output logic [CW-1:0]      o_held
);
	logic          sync1;
	logic          sync2;
	logic [7:0]    deb;
	logic          state;
	logic [CW-1:0] held;
	logic [7:0]    next_deb;
	logic          next_state;
	logic [CW-1:0] next_held;

	always_comb begin
		next_deb   = deb;
		next_state = state;
		next_held  = held;
		if (sync2 == state) begin
			next_deb = 8'h00;
		end else if (i_tick) begin
			if (deb == 8'(DEB - 1)) begin
				next_state = sync2;
				next_deb   = 8'h00;
			end else begin
				next_deb = deb + 8'h01;
			end
		end
		if (!state) begin
			next_held = '0;
		end else if (i_tick && held != '1) begin
			next_held = held + CW'(1);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			deb   <= 8'h00;
			state <= 1'b0;
			held  <= '0;
		end else begin
			sync1 <= i_pin;
			sync2 <= sync1;
			deb   <= next_deb;
			state <= next_state;
			held  <= next_held;
		end
	end

	assign o_down    = state;
	assign o_press   = next_state & ~state;
	assign o_release = ~next_state & state;
	assign o_held    = held;
endmodule
`default_nettype wire

// *** hdl/gssm_cmp.sv ***
`timescale 1ns/100ps
`default_nettype none
module gssm_cmp #(
	parameter int unsigned W = gssm_pkg::VAL_W
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_press,
	input  wire logic [W-1:0] i_on,
	input  wire logic [W-1:0] i_off,
	input  wire logic         i_disable_n,
	output logic              o_relay
);
	logic dis1;
	logic dis2;
	logic energized;
	logic next_energized;

	always_comb begin
		next_energized = energized;
		if (i_press < i_on) begin
			next_energized = 1'b1;
		end else if (i_press > i_off) begin
			next_energized = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			dis1      <= 1'b1;
			dis2      <= 1'b1;
			energized <= 1'b0;
			o_relay   <= 1'b0;
		end else begin
			dis1      <= i_disable_n;
			dis2      <= dis1;
			energized <= next_energized;
			o_relay   <= next_energized & dis2;
		end
	end
endmodule
`default_nettype wire

// *** hdl/gssm_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module gssm_top #(
	parameter int unsigned SEL_TICKS = gssm_pkg::SEL_HOLD_TICKS,
	parameter int unsigned DEF_TICKS = gssm_pkg::DEF_HOLD_TICKS,
	parameter int unsigned TICK_CYC  = gssm_pkg::TICK_CYCLES
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_key_select,
	input  wire logic        i_key_up,
	input  wire logic        i_key_down,
	input  wire logic        i_relay_disable_n,
	input  wire logic [15:0] i_pressure,
	output logic             o_relay,
	output logic [15:0]      o_disp_value,
	output logic [1:0]       o_disp_mode,
	output logic [15:0]      o_zero,
	output logic [15:0]      o_span,
	input  wire logic [5:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [5:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready
);
	localparam int CW = 14;

	logic [16:0]       tick_cnt;
	logic              tick;
	logic [2:0]        kdown;
	logic [2:0]        kpress;
	logic [2:0]        krel;
	logic [CW-1:0]     kheld [3];
	logic [2:0]        kpin;
	gssm_pkg::gssm_state_t state;
	gssm_pkg::gssm_state_t next_state;
	logic [15:0]       sp_on;
	logic [15:0]       sp_off;
	logic [15:0]       zero;
	logic [15:0]       span;
	logic [15:0]       edit;
	logic              sel_fired;
	logic [15:0]       next_sp_on;
	logic [15:0]       next_sp_off;
	logic [15:0]       next_zero;
	logic [15:0]       next_span;
	logic [15:0]       next_edit;
	logic              next_sel_fired;
	logic              sel_long;
	logic              up_long;
	logic              bw_pend;
	logic              sw_write;
	logic [5:0]        wr_addr;
	logic [15:0]       wr_data;

	// Free-running 1 ms timebase enable
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			tick_cnt <= 17'h00000;
		end else if (tick) begin
			tick_cnt <= 17'h00000;
		end else begin
			tick_cnt <= tick_cnt + 17'h00001;
		end
	end
	assign tick = (tick_cnt == 17'(TICK_CYC - 1));

	// Key order: 0 select, 1 up, 2 down
	assign kpin = {i_key_down, i_key_up, i_key_select};

	for (genvar k = 0; k < 3; k++) begin : g_key
		gssm_key #(
			.CW (CW)
		) u_key (
			.i_clock   (i_clock),
			.i_rst     (i_rst),
			.i_tick    (tick),
			.i_pin     (kpin[k]),
			.o_down    (kdown[k]),
			.o_press   (kpress[k]),
			.o_release (krel[k]),
			.o_held    (kheld[k])
		);
	end

	assign sel_long = kdown[0] && (kheld[0] >= CW'(SEL_TICKS));
	assign up_long  = kdown[1] && (kheld[1] >= CW'(DEF_TICKS));

	function automatic logic [15:0] bump(input logic [15:0] v, input logic up, input logic dn);
		if (up && v != 16'hffff) begin
			return v + 16'h0001;
		end else if (dn && v != 16'h0000) begin
			return v - 16'h0001;
		end
		return v;
	endfunction

	always_comb begin
		next_state     = state;
		next_sp_on     = sp_on;
		next_sp_off    = sp_off;
		next_zero      = zero;
		next_span      = span;
		next_edit      = edit;
		next_sel_fired = sel_fired;
		unique case (state)
			gssm_pkg::GSSM_NORMAL: begin
				if (sel_long && !sel_fired) begin
					next_state     = gssm_pkg::GSSM_SP_ON;
					next_edit      = sp_on;
					next_sel_fired = 1'b1;
				end else if (kpress[1]) begin
					next_state = gssm_pkg::GSSM_DEF;
				end
				if (!kdown[0]) begin
					next_sel_fired = 1'b0;
				end
			end
			gssm_pkg::GSSM_SP_ON: begin
				next_edit = bump(edit, kpress[1], kpress[2]);
				if (kpress[0] && !sel_fired) begin
					next_sp_on = edit;
					next_edit  = sp_off;
					next_state = gssm_pkg::GSSM_SP_OFF;
				end
				if (!kdown[0]) begin
					next_sel_fired = 1'b0;
				end
			end
			gssm_pkg::GSSM_SP_OFF: begin
				next_edit = bump(edit, kpress[1], kpress[2]);
				if (kpress[0]) begin
					next_sp_off = edit;
					next_edit   = gssm_pkg::CODE_ZERO;
					next_state  = gssm_pkg::GSSM_ZERO;
				end
			end
			gssm_pkg::GSSM_ZERO: begin
				if (kpress[2]) begin
					next_zero  = i_pressure;
					next_edit  = span;
					next_state = gssm_pkg::GSSM_SPAN;
				end else if (kpress[0]) begin
					next_edit      = span;
					next_state     = gssm_pkg::GSSM_SPAN;
					// Release of this press must not count as a span-step exit
					next_sel_fired = 1'b1;
				end
			end
			gssm_pkg::GSSM_SPAN: begin
				next_edit = bump(edit, kpress[1], kpress[2]);
				if (sel_long && !sel_fired) begin
					next_span      = edit;
					next_sel_fired = 1'b1;
					next_state     = gssm_pkg::GSSM_WAIT;
				end else if (krel[0] && !sel_fired) begin
					next_state = gssm_pkg::GSSM_NORMAL;
				end
				if (!kdown[0]) begin
					next_sel_fired = 1'b0;
				end
			end
			gssm_pkg::GSSM_DEF: begin
				if (up_long) begin
					next_sp_on  = gssm_pkg::DEF_ON_MTORR;
					next_sp_off = gssm_pkg::DEF_OFF_MTORR;
					next_zero   = gssm_pkg::DEF_ZERO_MTORR;
					next_span   = gssm_pkg::DEF_SPAN_TORR;
					next_state  = gssm_pkg::GSSM_WAIT;
				end else if (!kdown[1]) begin
					next_state = gssm_pkg::GSSM_NORMAL;
				end
			end
			gssm_pkg::GSSM_WAIT: begin
				// Wait for all keys free so a long hold does not re-trigger
				if (kdown == 3'b000) begin
					next_state     = gssm_pkg::GSSM_NORMAL;
					next_sel_fired = 1'b0;
				end
			end
			default: begin
				next_state = gssm_pkg::GSSM_NORMAL;
			end
		endcase
		// Software writes only in normal display, to avoid fighting the menu
		if (sw_write && state == gssm_pkg::GSSM_NORMAL) begin
			unique case (wr_addr)
				gssm_pkg::A_ON:   next_sp_on  = wr_data;
				gssm_pkg::A_OFF:  next_sp_off = wr_data;
				gssm_pkg::A_ZERO: next_zero   = wr_data;
				gssm_pkg::A_SPAN: next_span   = wr_data;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state     <= gssm_pkg::GSSM_NORMAL;
			sp_on     <= gssm_pkg::DEF_ON_MTORR;
			sp_off    <= gssm_pkg::DEF_OFF_MTORR;
			zero      <= gssm_pkg::DEF_ZERO_MTORR;
			span      <= gssm_pkg::DEF_SPAN_TORR;
			edit      <= 16'h0000;
			sel_fired <= 1'b0;
		end else begin
			state     <= next_state;
			sp_on     <= next_sp_on;
			sp_off    <= next_sp_off;
			zero      <= next_zero;
			span      <= next_span;
			edit      <= next_edit;
			sel_fired <= next_sel_fired;
		end
	end

	gssm_cmp u_cmp (
		.i_clock     (i_clock),
		.i_rst       (i_rst),
		.i_press     (i_pressure),
		.i_on        (sp_on),
		.i_off       (sp_off),
		.i_disable_n (i_relay_disable_n),
		.o_relay     (o_relay)
	);

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_disp_value <= 16'h0000;
			o_disp_mode  <= gssm_pkg::SHOW_PRESS;
		end else if (state == gssm_pkg::GSSM_NORMAL || state == gssm_pkg::GSSM_WAIT) begin
			o_disp_value <= i_pressure;
			o_disp_mode  <= gssm_pkg::SHOW_PRESS;
		end else if (state == gssm_pkg::GSSM_DEF) begin
			o_disp_value <= 16'h0000;
			o_disp_mode  <= gssm_pkg::SHOW_DEF_TEXT;
		end else begin
			o_disp_value <= edit;
			o_disp_mode  <= gssm_pkg::SHOW_VALUE;
		end
	end
	assign o_zero = zero;
	assign o_span = span;

	// AXI4-Lite slave: write taken when both address and data are valid and no write response is pending
	assign o_awready = i_awvalid && i_wvalid && !bw_pend;
	assign o_wready  = o_awready;
	assign sw_write  = o_awready && (i_wstrb[1:0] == 2'b11);
	assign wr_addr   = i_awaddr;
	assign wr_data   = i_wdata[15:0];
	assign o_arready = i_arvalid && !o_rvalid;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			bw_pend  <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp  <= gssm_pkg::RESP_OKAY;
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h00000000;
			o_rresp  <= gssm_pkg::RESP_OKAY;
		end else begin
			if (o_awready) begin
				bw_pend  <= 1'b1;
				o_bvalid <= 1'b1;
				o_bresp  <= (i_awaddr <= gssm_pkg::A_SPAN) ? gssm_pkg::RESP_OKAY
				                                          : gssm_pkg::RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				bw_pend  <= 1'b0;
				o_bvalid <= 1'b0;
			end
			if (o_arready) begin
				o_rvalid <= 1'b1;
				o_rresp  <= gssm_pkg::RESP_OKAY;
				unique case (i_araddr)
					gssm_pkg::A_ON:     o_rdata <= {16'h0000, sp_on};
					gssm_pkg::A_OFF:    o_rdata <= {16'h0000, sp_off};
					gssm_pkg::A_ZERO:   o_rdata <= {16'h0000, zero};
					gssm_pkg::A_SPAN:   o_rdata <= {16'h0000, span};
					gssm_pkg::A_STATUS: o_rdata <= {23'h000000, o_relay, 1'b0, state};
					gssm_pkg::A_PRESS:  o_rdata <= {16'h0000, i_pressure};
					default: begin
						o_rdata <= 32'h00000000;
						o_rresp <= gssm_pkg::RESP_SLVERR;
					end
				endcase
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** verification/gssm_top_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module gssm_top_props #(
	parameter int unsigned SEL_TICKS = 5,
	parameter int unsigned TICK_CYC  = 10
) (
	input wire logic        i_clock,
	input wire logic        i_rst,
	input wire logic        i_key_select,
	input wire logic        i_key_down,
	input wire logic        i_relay_disable_n,
	input wire logic        i_awvalid,
	input wire logic        i_wvalid,
	input wire logic        i_arvalid,
	input wire logic        o_relay,
	input wire logic [15:0] o_disp_value,
	input wire logic [1:0]  o_disp_mode,
	input wire logic [15:0] o_zero,
	input wire logic [15:0] o_span,
	input wire logic        o_awready,
	input wire logic        o_wready,
	input wire logic        o_bvalid,
	input wire logic        o_arready,
	input wire logic        o_rvalid
);
	// Raw pin hold; debounce only adds to it, so this is a safe lower bound
	logic [15:0] sel_cnt;
	logic [15:0] next_sel_cnt;
	always_comb begin
		next_sel_cnt = sel_cnt;
		if (!i_key_select)
			next_sel_cnt = 16'h0;
		else if (sel_cnt != 16'hffff)
			next_sel_cnt = sel_cnt + 16'h1;
	end
	always_ff @(posedge i_clock) begin
		sel_cnt <= i_rst ? 16'h0 : next_sel_cnt;
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	sequence s_dis_low;
		!i_relay_disable_n [*6];
	endsequence
	sequence s_wr_take;
		i_awvalid && i_wvalid && o_awready && o_wready;
	endsequence
	sequence s_rd_take;
		i_arvalid && o_arready;
	endsequence
	AST_RELAY_OFF: assert property (s_dis_low |-> !o_relay)
		else $error("relay on while disabled");
	AST_MENU_ENTRY: assert property (
		$past(o_disp_mode) == gssm_pkg::SHOW_PRESS && o_disp_mode == gssm_pkg::SHOW_VALUE
		|-> sel_cnt >= SEL_TICKS * TICK_CYC) else $error("setup entered on short select");
	AST_SPAN_STORE: assert property (
		$past(o_disp_mode) == gssm_pkg::SHOW_VALUE && $changed(o_span)
		|-> sel_cnt >= SEL_TICKS * TICK_CYC) else $error("span stored without long select");
	AST_ZERO_CAPTURE: assert property (
		$past(o_disp_mode) == gssm_pkg::SHOW_VALUE && $changed(o_zero) |-> i_key_down)
		else $error("zero stored without down key");
	AST_DEF_LOAD: assert property (
		$past(o_disp_mode) == gssm_pkg::SHOW_DEF_TEXT && $changed(o_span)
		|-> o_span == 16'h02f8 && o_zero == 16'h0000) else $error("defaults wrong");
	AST_DEF_TEXT: assert property (o_disp_mode == gssm_pkg::SHOW_DEF_TEXT |-> o_disp_value == 16'h0)
		else $error("default text shows a value");
	AST_B_ANSWER: assert property (s_wr_take |=> o_bvalid)
		else $error("write response missing");
	AST_R_ANSWER: assert property (s_rd_take |=> o_rvalid)
		else $error("read response missing");
	AST_B_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write taken while response pending");
	AST_R_BLOCK: assert property (o_rvalid |-> !o_arready)
		else $error("read taken while response pending");
endmodule
bind gssm_top gssm_top_props #(.SEL_TICKS(SEL_TICKS), .TICK_CYC(TICK_CYC)) props_u (
	.i_clock, .i_rst, .i_key_select, .i_key_down, .i_relay_disable_n, .i_awvalid,
	.i_wvalid, .i_arvalid, .o_relay, .o_disp_value, .o_disp_mode, .o_zero, .o_span,
	.o_awready, .o_wready, .o_bvalid, .o_arready, .o_rvalid);
`default_nettype wire

// *** verification/gssm_op.sv ***
`timescale 1ns/100ps
`default_nettype none
module gssm_op (
	input  wire logic i_clock,
	output logic      o_key_select,
	output logic      o_key_up,
	output logic      o_key_down
);
	initial begin
		{o_key_down, o_key_up, o_key_select} = 3'h0;
	end
	// One switch position at a time; contacts chatter for 8 cycles on closing
	task automatic push(input int k, input int hold);
		logic [2:0] m;
		m = 3'h1 << k;
		for (int i = 0; i < hold + 8; i++) begin
			@(posedge i_clock);
			{o_key_down, o_key_up, o_key_select} <= (i < 8 && i[0]) ? 3'h0 : m;
		end
		@(posedge i_clock);
		{o_key_down, o_key_up, o_key_select} <= 3'h0;
		repeat (150) @(posedge i_clock);
	endtask
endmodule
`default_nettype wire

// *** verification/gssm_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module gssm_top_tb;
	logic        i_clock = 1'b0;
	logic        i_rst, i_relay_disable_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic        i_key_select, i_key_up, i_key_down, o_relay, o_awready, o_wready, o_bvalid;
	logic        o_arready, o_rvalid;
	logic [15:0] i_pressure, o_disp_value, o_zero, o_span;
	logic [5:0]  i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0]  i_wstrb;
	logic [1:0]  o_disp_mode, o_bresp, o_rresp;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cyc = 0;
	always #4 i_clock = ~i_clock;
	gssm_op op_u (.i_clock, .o_key_select(i_key_select), .o_key_up(i_key_up),
		.o_key_down(i_key_down));
	gssm_top #(.SEL_TICKS(30), .DEF_TICKS(50), .TICK_CYC(10)) dut_u (.i_clock, .i_rst,
		.i_key_select, .i_key_up, .i_key_down, .i_relay_disable_n, .i_pressure, .o_relay,
		.o_disp_value, .o_disp_mode, .o_zero, .o_span, .i_awaddr, .i_awvalid, .o_awready,
		.i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
		.i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
	task automatic print_verdict();
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge i_clock);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do @(negedge i_clock); while (o_awready !== 1'b1);
		@(posedge i_clock);
		i_awvalid <= 1'b0;
		i_wvalid <= 1'b0;
		do @(negedge i_clock); while (o_bvalid !== 1'b1);
		r = o_bresp;
		@(posedge i_clock);
		i_bready <= 1'b0;
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge i_clock);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do @(negedge i_clock); while (o_arready !== 1'b1);
		@(posedge i_clock);
		i_arvalid <= 1'b0;
		do @(negedge i_clock); while (o_rvalid !== 1'b1);
		chk("rdata", e, o_rdata);
		chk("rresp", er, o_rresp);
		@(posedge i_clock);
		i_rready <= 1'b0;
	endtask
	task automatic t_regs();
		logic [1:0] r;
		rchk(6'h00, 32'h64, 2'h0);
		rchk(6'h04, 32'hc8, 2'h0);
		rchk(6'h08, 32'h0, 2'h0);
		rchk(6'h0c, 32'h2f8, 2'h0);
		rchk(6'h18, 32'h0, 2'h2);
		rchk(6'h10, 32'h1, 2'h0);
		rchk(6'h14, 32'h12c, 2'h0);
		wr(6'h10, 32'h1, r);
		chk("bresp", 32'h2, r);
		wr(6'h0c, 32'h12c, r);
		chk("bresp", 32'h0, r);
		chk("span", 32'h12c, o_span);
		i_wstrb <= 4'h0;
		wr(6'h08, 32'h55, r);
		chk("bresp", 32'h0, r);
		chk("zero", 32'h0, o_zero);
		i_wstrb <= 4'hf;
	endtask
	task automatic t_relay();
		logic [15:0] p [6] = '{16'h12c, 16'h96, 16'h32, 16'h96, 16'hfa, 16'h32};
		logic        e [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 6; i++) begin
			@(posedge i_clock);
			i_pressure <= p[i];
			repeat (8) @(posedge i_clock);
			chk("relay", e[i], o_relay);
		end
		i_relay_disable_n <= 1'b0;
		repeat (8) @(posedge i_clock);
		chk("relay", 32'h0, o_relay);
		i_relay_disable_n <= 1'b1;
		repeat (8) @(posedge i_clock);
		chk("relay", 32'h1, o_relay);
	endtask
	task automatic t_menu1();
		op_u.push(0, 500);
		chk("mode", 32'h1, o_disp_mode);
		chk("value", 32'h64, o_disp_value);
		op_u.push(1, 140);
		chk("value", 32'h65, o_disp_value);
		op_u.push(0, 140);
		chk("value", 32'hc8, o_disp_value);
		op_u.push(0, 140);
		chk("value", 32'h0, o_disp_value);
		i_pressure <= 16'h123;
		op_u.push(2, 140);
		chk("zero", 32'h123, o_zero);
		chk("value", 32'h12c, o_disp_value);
		op_u.push(1, 140);
		op_u.push(0, 140);
		chk("mode", 32'h0, o_disp_mode);
		chk("span", 32'h12c, o_span);
		rchk(6'h00, 32'h65, 2'h0);
	endtask
	task automatic t_menu2();
		i_pressure <= 16'h50;
		op_u.push(0, 500);
		op_u.push(0, 140);
		op_u.push(0, 140);
		op_u.push(0, 140);
		chk("zero", 32'h123, o_zero);
		op_u.push(2, 140);
		chk("value", 32'h12b, o_disp_value);
		op_u.push(0, 500);
		chk("span", 32'h12b, o_span);
		chk("mode", 32'h0, o_disp_mode);
	endtask
	task automatic t_def();
		fork
			op_u.push(1, 140);
			begin
				repeat (130) @(posedge i_clock);
				chk("mode", 32'h2, o_disp_mode);
			end
		join
		chk("mode", 32'h0, o_disp_mode);
		chk("span", 32'h12b, o_span);
		op_u.push(1, 700);
		chk("span", 32'h2f8, o_span);
		chk("zero", 32'h0, o_zero);
		rchk(6'h00, 32'h64, 2'h0);
		rchk(6'h04, 32'hc8, 2'h0);
	endtask
	initial begin
		{i_rst, i_relay_disable_n} = 2'h3;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
		{i_awaddr, i_araddr, i_wdata} = 44'h0;
		i_wstrb = 4'hf;
		i_pressure = 16'h12c;
		repeat (8) @(posedge i_clock);
		i_rst <= 1'b0;
		t_regs();
		t_relay();
		t_menu1();
		t_menu2();
		t_def();
		print_verdict();
	end
endmodule
`default_nettype wire
